// >>> system_core_clock_sleep_clock_manager.sv
// System clock select, sleep clock control, monitor output and CPU modes
// Notes on behaviour
// - Reset selects fast internal as system source
// - Software may change source and divider later
// - Protected writes need key 0x0096 held
// - Sleep instruction enters sleep mode, halts CPU
// - Sleep stops sources whose sleep-stop bit set
// - Sources with sleep-stop bit clear keep running
// - Wake reload works only with enable bit 1
// - Wake copies wake fields into active fields
// - Source codes 0..3; divider 1,2,4,8
// - Sleep-stop 1 stops; 0 keeps prior state
// - Monitor pin carries divided source when enabled
// - Stop detected with restart set restarts oscillator
// - Stop flag on clock stop or enable falls
// - Stable flags set after wait; clear by 1
// - Interrupt only when flag and enable both set
// - Halt stops CPU, clocks keep running
// - Wake causes return to run mode
// - Reset release enters run mode
// - Debug interrupt enters, return instruction leaves debug
//
// Implementation choices: strobed register access and the register offsets.
module system_core_clock_sleep_clock_manager
  import clock_manager_pkg::*;
#(
  parameter int LOW_WAIT_EDGES    = 16384,
  parameter int SECOND_WAIT_EDGES = 64
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  // Register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [15:0]      o_rdata,
  // Oscillator clocks and run enables
  input  wire logic [3:0]  i_src_clk,
  output logic [3:0]       o_osc_run,
  // CPU events
  input  wire logic        i_sys_rst_req,
  input  wire logic        i_halt_exec,
  input  wire logic        i_sleep_exec,
  input  wire logic        i_periph_irq,
  input  wire logic        i_wdt_nmi,
  input  wire logic        i_debug_irq,
  input  wire logic        i_debug_ret,
  output logic             o_cpu_exec,
  output logic [1:0]       o_cpu_mode,
  // Clock outputs and interrupt
  output logic             o_sys_clk_en,
  output logic             o_monitor_out,
  output logic             o_clk_irq
);

  // ==========================================================
  // Registers
  logic [15:0] key_q;
  logic [1:0]  src_q, div_q, wsrc_q, wdiv_q;
  logic        wmd_q;
  logic [3:0]  osc_en_q, slpc_q;
  logic        restart_en_q, detect_en_q;
  logic        mon_en_q;
  logic [1:0]  mon_src_q;
  logic [2:0]  mon_div_q;
  logic [5:0]  flag_q, irq_en_q;
  logic [1:0]  cur_src_q;
  cpu_mode_t   mode_q;
  logic        unlocked, wake, stop_evt;
  logic        wake_reload;
  logic [3:0]  stable, done;

  function automatic logic wr_at(input logic [3:0] a);
    return i_wr && (i_addr == a);
  endfunction

  assign unlocked    = (key_q == UNLOCK_KEY);
  assign wake        = i_periph_irq || i_wdt_nmi || i_debug_irq ||
                       i_sys_rst_req;
  assign wake_reload = (mode_q == MODE_SLEEP) && wake && wmd_q;

  // ==========================================================
  // Protection key
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      key_q <= 16'h0000;
    end else if (wr_at(REG_PROTECT)) begin
      key_q <= i_wdata;
    end
  end

  // ==========================================================
  // System clock control
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      src_q  <= SYSTEM_CORE_CLOCK_RST[SCLK_SRC_LSB +: 2];
      div_q  <= SYSTEM_CORE_CLOCK_RST[SCLK_DIV_LSB +: 2];
      wsrc_q <= SYSTEM_CORE_CLOCK_RST[SCLK_WSRC_LSB +: 2];
      wdiv_q <= SYSTEM_CORE_CLOCK_RST[SCLK_WDIV_LSB +: 2];
      wmd_q  <= SYSTEM_CORE_CLOCK_RST[SCLK_WMD_BIT];
    end else if (wake_reload) begin
      src_q <= wsrc_q;
      div_q <= wdiv_q;
    end else if (wr_at(REG_SYSTEM_CORE_CLOCK) && unlocked) begin
      src_q  <= i_wdata[SCLK_SRC_LSB +: 2];
      div_q  <= i_wdata[SCLK_DIV_LSB +: 2];
      wsrc_q <= i_wdata[SCLK_WSRC_LSB +: 2];
      wdiv_q <= i_wdata[SCLK_WDIV_LSB +: 2];
      wmd_q  <= i_wdata[SCLK_WMD_BIT];
    end
  end

  // ==========================================================
  // Oscillator enables and sleep-stop bits
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      osc_en_q <= OSC_EN_RST;
      slpc_q   <= OSC_SLPC_RST;
    end else if (wake_reload) begin
      // Only the new source and sleep-kept sources stay on
      for (int i = 0; i < 4; i++) begin
        if (2'(i) != wsrc_q && slpc_q[i]) begin
          osc_en_q[i] <= 1'b0;
        end
      end
    end else if (wr_at(REG_OSC_CTRL)) begin
      osc_en_q <= i_wdata[OSC_EN_LSB +: 4];
      slpc_q   <= i_wdata[OSC_SLPC_LSB +: 4];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      restart_en_q <= RESTART_RST;
      detect_en_q  <= DETECT_RST;
    end else if (wr_at(REG_LOW_CTRL) && unlocked) begin
      restart_en_q <= i_wdata[LOW_RESTART_BIT];
      detect_en_q  <= i_wdata[LOW_DETECT_BIT];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      mon_en_q  <= 1'b0;
      mon_src_q <= SRC_FAST;
      mon_div_q <= 3'h0;
    end else if (wr_at(REG_MONITOR)) begin
      mon_en_q  <= i_wdata[MON_EN_BIT];
      mon_src_q <= i_wdata[MON_SRC_LSB +: 2];
      mon_div_q <= i_wdata[MON_DIV_LSB +: 3];
    end
  end

  // ==========================================================
  // Source run control: a selected source starts itself
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      o_osc_run[i] = osc_en_q[i] || (2'(i) == src_q);
      if (mode_q == MODE_SLEEP && slpc_q[i]) begin
        o_osc_run[i] = 1'b0;
      end
    end
  end

  // ==========================================================
  // Source clock synchronisers and edge detect
  logic [3:0] sync1_q, sync2_q, sync3_q, edge_s;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= i_src_clk;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign edge_s = sync2_q & ~sync3_q;

  // ==========================================================
  // Stabilization waits; the external input has none
  logic        low_restart;
  localparam int WW = 17;

  osc_stabilizer #(.WAIT_W(WW)) u_fast (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_run     (o_osc_run[SRC_FAST]),
    .i_restart (1'b0),
    .i_edge    (edge_s[SRC_FAST]),
    .i_wait    (WW'(FAST_WAIT_EDGES)),
    .o_stable  (stable[SRC_FAST]),
    .o_done    (done[SRC_FAST])
  );

  osc_stabilizer #(.WAIT_W(WW)) u_low (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_run     (o_osc_run[SRC_LOW]),
    .i_restart (low_restart),
    .i_edge    (edge_s[SRC_LOW]),
    .i_wait    (WW'(LOW_WAIT_EDGES)),
    .o_stable  (stable[SRC_LOW]),
    .o_done    (done[SRC_LOW])
  );

  osc_stabilizer #(.WAIT_W(WW)) u_second (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_run     (o_osc_run[SRC_SECOND]),
    .i_restart (1'b0),
    .i_edge    (edge_s[SRC_SECOND]),
    .i_wait    (WW'(SECOND_WAIT_EDGES)),
    .o_stable  (stable[SRC_SECOND]),
    .o_done    (done[SRC_SECOND])
  );

  assign stable[SRC_EXT] = o_osc_run[SRC_EXT];
  assign done[SRC_EXT]   = 1'b0;

  // ==========================================================
  // Low-speed stop detector
  logic [11:0] quiet_q;
  logic        low_en_d1_q, det_en_d1_q;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      quiet_q     <= '0;
      low_en_d1_q <= 1'b0;
      det_en_d1_q <= 1'b0;
    end else begin
      low_en_d1_q <= osc_en_q[SRC_LOW];
      det_en_d1_q <= detect_en_q;
      if (edge_s[SRC_LOW] || !detect_en_q || !stable[SRC_LOW] ||
          stop_evt) begin
        quiet_q <= '0;
      end else begin
        quiet_q <= quiet_q + 12'h001;
      end
    end
  end

  // Timed out with no edge, or an enable fell
  assign stop_evt = (quiet_q == 12'(STOP_TIMEOUT_CYC - 1)) ||
                    (low_en_d1_q && !osc_en_q[SRC_LOW]) ||
                    (det_en_d1_q && !detect_en_q);
  // Restart reruns the full stabilization wait
  assign low_restart = (quiet_q == 12'(STOP_TIMEOUT_CYC - 1)) &&
                       restart_en_q;

  // ==========================================================
  // Interrupt flags and enables
  logic [5:0] set_v;

  assign set_v = {stop_evt, 2'b00, done[2:0]};

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      flag_q <= '0;
    end else begin
      // A set in the clearing cycle wins
      flag_q <= (flag_q & ~({6{wr_at(REG_INT_FLAG)}} & i_wdata[5:0]))
                | set_v;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      irq_en_q <= '0;
    end else if (wr_at(REG_INT_EN)) begin
      irq_en_q <= i_wdata[5:0] & 6'h27;
    end
  end

  assign o_clk_irq = |(flag_q & irq_en_q);

  // ==========================================================
  // Glitch-free source changeover
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      cur_src_q <= SRC_FAST;
    end else if (src_q != cur_src_q && stable[src_q]) begin
      cur_src_q <= src_q;
    end
  end

  // ==========================================================
  // System and monitor dividers
  tick_div_if sys_div ();
  tick_div_if mon_div ();

  assign sys_div.tick  = edge_s[cur_src_q] && stable[cur_src_q];
  assign sys_div.ratio = {1'b0, div_q};
  assign mon_div.tick  = edge_s[mon_src_q] && mon_en_q;
  assign mon_div.ratio = mon_div_q;

  pow2_divider u_sys_div (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .port      (sys_div.div)
  );

  pow2_divider u_mon_div (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .port      (mon_div.div)
  );

  // Halt keeps clocks, sleep gates the core enable
  assign o_sys_clk_en = sys_div.pulse && (mode_q != MODE_SLEEP);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || !mon_en_q) begin
      o_monitor_out <= 1'b0;
    end else if (mon_div.pulse) begin
      o_monitor_out <= ~o_monitor_out;
    end
  end

  // ==========================================================
  // CPU operating mode
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || i_sys_rst_req) begin
      mode_q <= MODE_RUN;
    end else begin
      case (mode_q)
        MODE_RUN: begin
          if (i_debug_irq) begin
            mode_q <= MODE_DEBUG;
          end else if (i_sleep_exec) begin
            mode_q <= MODE_SLEEP;
          end else if (i_halt_exec) begin
            mode_q <= MODE_HALT;
          end
        end
        MODE_HALT, MODE_SLEEP: begin
          if (i_debug_irq) begin
            mode_q <= MODE_DEBUG;
          end else if (wake) begin
            mode_q <= MODE_RUN;
          end
        end
        MODE_DEBUG: begin
          if (i_debug_ret) begin
            mode_q <= MODE_RUN;
          end
        end
        default: mode_q <= MODE_RUN;
      endcase
    end
  end

  assign o_cpu_exec = (mode_q == MODE_RUN) ||
                      (mode_q == MODE_DEBUG);
  assign o_cpu_mode = mode_q;

  // ==========================================================
  // Read port, data in the cycle after the strobe
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || !i_rd) begin
      o_rdata <= 16'h0000;
    end else begin
      case (i_addr)
        REG_PROTECT:  o_rdata <= key_q;
        REG_SYSTEM_CORE_CLOCK:   o_rdata <= {wmd_q, 1'b0, wdiv_q, 2'b00, wsrc_q,
                                  2'b00, div_q, 2'b00, src_q};
        REG_OSC_CTRL: o_rdata <= {4'h0, slpc_q, 4'h0, osc_en_q};
        REG_LOW_CTRL: o_rdata <= {1'b0, restart_en_q, detect_en_q,
                                  13'h0000};
        REG_MONITOR:  o_rdata <= {9'h000, mon_div_q, mon_src_q,
                                  1'b0, mon_en_q};
        REG_INT_FLAG: o_rdata <= {10'h000, flag_q};
        REG_INT_EN:   o_rdata <= {10'h000, irq_en_q};
        REG_STATUS:   o_rdata <= {8'h00, stable, cur_src_q, mode_q};
        default:      o_rdata <= 16'h0000;
      endcase
    end
  end

endmodule // system_core_clock_sleep_clock_manager

// >>> clock_manager_pkg.sv
// Constants shared by the system clock manager and its helpers
package clock_manager_pkg;

  // ==========================================================
  // Register indices on the plain register port
  localparam logic [3:0] REG_PROTECT   = 4'h0;
  localparam logic [3:0] REG_SYSTEM_CORE_CLOCK    = 4'h1;
  localparam logic [3:0] REG_OSC_CTRL  = 4'h2;
  localparam logic [3:0] REG_LOW_CTRL  = 4'h3;
  localparam logic [3:0] REG_MONITOR   = 4'h4;
  localparam logic [3:0] REG_INT_FLAG  = 4'h5;
  localparam logic [3:0] REG_INT_EN    = 4'h6;
  localparam logic [3:0] REG_STATUS    = 4'h7;

  // ==========================================================
  // Protection key and field positions
  localparam logic [15:0] UNLOCK_KEY   = 16'h0096;
  localparam int SCLK_SRC_LSB  = 0;
  localparam int SCLK_DIV_LSB  = 4;
  localparam int SCLK_WSRC_LSB = 8;
  localparam int SCLK_WDIV_LSB = 12;
  localparam int SCLK_WMD_BIT  = 15;
  localparam int OSC_EN_LSB    = 0;
  localparam int OSC_SLPC_LSB  = 8;
  localparam int LOW_RESTART_BIT = 14;
  localparam int LOW_DETECT_BIT  = 13;
  localparam int MON_EN_BIT    = 0;
  localparam int MON_SRC_LSB   = 2;
  localparam int MON_DIV_LSB   = 4;
  localparam int FLAG_STOP_BIT = 5;

  // ==========================================================
  // Reset values
  localparam logic [15:0] SYSTEM_CORE_CLOCK_RST   = 16'h0000;
  localparam logic [3:0]  OSC_EN_RST   = 4'h1;
  localparam logic [3:0]  OSC_SLPC_RST = 4'hf;
  localparam logic        RESTART_RST  = 1'b1;
  localparam logic        DETECT_RST   = 1'b0;

  // ==========================================================
  // Sources and timing
  localparam logic [1:0] SRC_FAST   = 2'h0;
  localparam logic [1:0] SRC_LOW    = 2'h1;
  localparam logic [1:0] SRC_SECOND = 2'h2;
  localparam logic [1:0] SRC_EXT    = 2'h3;
  localparam int FAST_WAIT_EDGES    = 16;
  localparam int REF_CLK_KHZ        = 25000;
  localparam int STOP_TIMEOUT_US    = 100;
  localparam int STOP_TIMEOUT_CYC   =
    STOP_TIMEOUT_US * REF_CLK_KHZ / 1000;

  typedef enum logic [1:0] {
    MODE_RUN, MODE_HALT, MODE_SLEEP, MODE_DEBUG
  } cpu_mode_t;

endpackage

// >>> tick_div_if.sv
// Carries a source edge and a ratio into a divider, and its pulse back
interface tick_div_if;
  logic       tick;
  logic [2:0] ratio;
  logic       pulse;
  modport ctl (output tick, output ratio, input pulse);
  modport div (input tick, input ratio, output pulse);
endinterface

// >>> osc_stabilizer.sv
// Counts source edges after start until the stabilization wait is over
module osc_stabilizer #(
  parameter int WAIT_W = 17
) (
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_b,
  // Control
  input  wire logic              i_run,
  input  wire logic              i_restart,
  input  wire logic              i_edge,
  input  wire logic [WAIT_W-1:0] i_wait,
  // Status
  output logic                   o_stable,
  output logic                   o_done
);
  logic [WAIT_W-1:0] cnt_q;

  // Wait is always spent again at every start, whatever the flag says
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || !i_run || i_restart) begin
      cnt_q    <= '0;
      o_stable <= 1'b0;
      o_done   <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!o_stable && i_edge) begin
        cnt_q <= cnt_q + 1'b1;
        if (cnt_q + 1'b1 >= i_wait) begin
          o_stable <= 1'b1;
          o_done   <= 1'b1;
        end
      end
    end
  end
endmodule // osc_stabilizer

// >>> pow2_divider.sv
// Passes one pulse out of every 2**ratio input ticks
module pow2_divider (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_b,
  // Tick path
  tick_div_if.div   port
);
  logic [6:0] cnt_q;
  logic [6:0] last;

  assign last = 7'((8'h01 << port.ratio) - 8'h01);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      cnt_q      <= '0;
      port.pulse <= 1'b0;
    end else begin
      port.pulse <= 1'b0;
      if (port.tick) begin
        if (cnt_q >= last) begin
          cnt_q      <= '0;
          port.pulse <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 7'h01;
        end
      end
    end
  end
endmodule // pow2_divider

// >>> clock_manager_props.sv
// Port-level checks for the system clock manager
module clock_manager_props
  import clock_manager_pkg::*;
(
  // Clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_rst_b,
  // Register port
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  // CPU events
  input wire logic        i_sys_rst_req,
  input wire logic        i_halt_exec,
  input wire logic        i_sleep_exec,
  input wire logic        i_periph_irq,
  input wire logic        i_wdt_nmi,
  input wire logic        i_debug_irq,
  input wire logic        i_debug_ret,
  // Outputs under watch
  input wire logic [3:0]  o_osc_run,
  input wire logic        o_cpu_exec,
  input wire logic [1:0]  o_cpu_mode,
  input wire logic        o_sys_clk_en,
  input wire logic        o_clk_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  // ==========================================================
  // Assertions
  a_reset_run_state: assert property (
    $rose(i_rst_b) |-> o_cpu_mode == MODE_RUN && o_osc_run == 4'h1)
    else $error("state after reset release is off");
  a_sleep_enter: assert property (
    o_cpu_mode == MODE_RUN && i_sleep_exec && !i_debug_irq
    && !i_sys_rst_req |=> o_cpu_mode == MODE_SLEEP)
    else $error("sleep not entered");
  a_halt_enter: assert property (
    o_cpu_mode == MODE_RUN && i_halt_exec && !i_sleep_exec
    && !i_debug_irq && !i_sys_rst_req |=> o_cpu_mode == MODE_HALT)
    else $error("halt not entered");
  a_exec_by_mode: assert property (
    o_cpu_exec == (o_cpu_mode inside {MODE_RUN, MODE_DEBUG}))
    else $error("execution enable disagrees with mode");
  a_wake_to_run: assert property (
    o_cpu_mode inside {MODE_HALT, MODE_SLEEP} && !i_debug_irq
    && (i_periph_irq || i_wdt_nmi) |=> o_cpu_mode == MODE_RUN)
    else $error("wake cause did not return to run");
  a_debug_enter: assert property (
    i_debug_irq && !i_sys_rst_req && o_cpu_mode != MODE_DEBUG
    |=> o_cpu_mode == MODE_DEBUG)
    else $error("debug not entered");
  a_debug_leave: assert property (
    o_cpu_mode == MODE_DEBUG && i_debug_ret && !i_debug_irq
    && !i_sys_rst_req |=> o_cpu_mode == MODE_RUN)
    else $error("debug not left");
  a_sysreq_to_run: assert property (
    i_sys_rst_req |=> o_cpu_mode == MODE_RUN)
    else $error("reset request did not give run");
  a_sleep_no_core: assert property (
    $past(o_cpu_mode) == MODE_SLEEP && o_cpu_mode == MODE_SLEEP
    |-> !o_sys_clk_en)
    else $error("core clock enable pulsed in sleep");
  a_halt_keeps_osc: assert property (
    $past(o_cpu_mode) == MODE_RUN && o_cpu_mode == MODE_HALT
    |-> o_osc_run == $past(o_osc_run))
    else $error("halt changed source run enables");
  a_read_idle_zero: assert property (
    !$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data outside its cycle");

  // Main scenarios reached
  c_sleep: cover property (o_cpu_mode == MODE_SLEEP);
  c_halt: cover property (o_cpu_mode == MODE_HALT);
  c_debug: cover property (o_cpu_mode == MODE_DEBUG);
  c_irq: cover property ($rose(o_clk_irq));
endmodule // clock_manager_props

bind system_core_clock_sleep_clock_manager clock_manager_props u_props (
  .i_ref_clk, .i_rst_b, .i_rd, .o_rdata, .i_sys_rst_req, .i_halt_exec,
  .i_sleep_exec, .i_periph_irq, .i_wdt_nmi, .i_debug_irq, .i_debug_ret,
  .o_osc_run, .o_cpu_exec, .o_cpu_mode, .o_sys_clk_en, .o_clk_irq
);

// >>> osc_bank_model.sv
// Oscillator bank standing behind the clock manager's source inputs
module osc_bank_model (
  // Run enables from the block
  input  wire logic [3:0] i_osc_run,
  // Forced failure of the low-speed crystal
  input  wire logic       i_low_fail,
  // Source clocks
  output logic [3:0]      o_src_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  // Periods unrelated to the reference clock and to each other
  localparam int HALF [4] = '{85, 205, 115, 145};

  // ==========================================================
  // Sources
  for (genvar g = 0; g < 4; g++) begin : g_osc
    initial o_src_clk[g] = 1'b0;
    // A stopped source stands still; it restarts once enabled again
    always begin
      #(HALF[g]);
      if (i_osc_run[g] && !(g == 1 && i_low_fail)) begin
        o_src_clk[g] = ~o_src_clk[g];
      end
    end
  end
endmodule // osc_bank_model

// >>> testbench.sv
// Register-level test sequence for the system clock manager
module testbench
  import clock_manager_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        rst_b;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [6:0]  ev;  // Events: rst_req halt sleep periph nmi dbg_irq dbg_ret
  logic        low_fail;
  logic [15:0] rdata;
  logic [3:0]  src_clk;
  logic [3:0]  osc_run;
  logic [1:0]  mode;
  logic        exec;
  logic        sclk_en;
  logic        mon;
  logic        irq;
  logic        mon_q = 1'b0;
  int          mon_t;
  int          clk_t;
  int          failures = 0;
  int          cmp_count = 0;

  always #20 ref_clk = ~ref_clk;
  // Counted off the falling edge, where outputs have settled
  always @(negedge ref_clk) begin
    mon_t += int'(mon !== mon_q);
    clk_t += int'(sclk_en === 1'b1);
    mon_q = mon;
  end

  system_core_clock_sleep_clock_manager #(.LOW_WAIT_EDGES(8), .SECOND_WAIT_EDGES(4))
  i_dut (
    .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_src_clk(src_clk),
    .o_osc_run(osc_run), .i_sys_rst_req(ev[0]), .i_halt_exec(ev[1]),
    .i_sleep_exec(ev[2]), .i_periph_irq(ev[3]), .i_wdt_nmi(ev[4]),
    .i_debug_irq(ev[5]), .i_debug_ret(ev[6]), .o_cpu_exec(exec),
    .o_cpu_mode(mode), .o_sys_clk_en(sclk_en), .o_monitor_out(mon),
    .o_clk_irq(irq));
  osc_bank_model i_osc (
    .i_osc_run(osc_run), .i_low_fail(low_fail), .o_src_clk(src_clk));

  // ==========================================================
  // Tasks
  task automatic conclude();
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(string nm, logic [3:0] a, logic [15:0] m,
                        logic [15:0] e);
    logic [15:0] d;
    reg_rd(a, d);
    chk(nm, e, d & m);
  endtask
  // Polls a field; a wait that runs out ends the run
  task automatic wait_reg(logic [3:0] a, logic [15:0] m, logic [15:0] e);
    logic [15:0] d;
    for (int n = 0; n < 2000; n++) begin
      reg_rd(a, d);
      if ((d & m) === e) return;
    end
    failures++;
    conclude();
  endtask
  task automatic pulse(input int b);
    @(posedge ref_clk);
    ev[b] <= 1'b1;
    @(posedge ref_clk);
    ev[b] <= 1'b0;
    #1;
  endtask
  task automatic chk_mode(string nm, logic [1:0] e, logic x);
    chk(nm, {14'h0, e}, {14'h0, mode});
    chk("exec", {15'h0, x}, {15'h0, exec});
  endtask

  // ==========================================================
  // Sequence
  initial begin
    {rst_b, addr, wdata, wr, rd, ev, low_fail} = '0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1 chk("run enables", 16'h0001, {12'h0, osc_run});
    rd_chk("system_core_clock reset", REG_SYSTEM_CORE_CLOCK, 16'hffff, SYSTEM_CORE_CLOCK_RST);
    rd_chk("osc reset", REG_OSC_CTRL, 16'h0f0f, 16'h0f01);
    rd_chk("low reset", REG_LOW_CTRL, 16'h6000, 16'h4000);
    rd_chk("unmapped", 4'hf, 16'hffff, 16'h0000);
    wait_reg(REG_INT_FLAG, 16'h0001, 16'h0001);
    chk("irq masked", 16'h0000, {15'h0, irq});
    reg_wr(REG_INT_EN, 16'h0001);
    chk("irq on", 16'h0001, {15'h0, irq});
    reg_wr(REG_INT_FLAG, 16'h0001);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    // Protected source switch to low speed, divide by 2
    reg_wr(REG_SYSTEM_CORE_CLOCK, 16'h0011);
    rd_chk("locked", REG_SYSTEM_CORE_CLOCK, 16'hffff, 16'h0000);
    reg_wr(REG_PROTECT, UNLOCK_KEY);
    reg_wr(REG_SYSTEM_CORE_CLOCK, 16'h0011);
    rd_chk("src held", REG_STATUS, 16'h000c, 16'h0000);
    rd_chk("unlocked", REG_SYSTEM_CORE_CLOCK, 16'hffff, 16'h0011);
    wait_reg(REG_STATUS, 16'h000c, 16'h0004);
    rd_chk("low stable", REG_INT_FLAG, 16'h0002, 16'h0002);
    reg_wr(REG_PROTECT, 16'h0001);
    reg_wr(REG_SYSTEM_CORE_CLOCK, 16'h0000);
    rd_chk("relocked", REG_SYSTEM_CORE_CLOCK, 16'hffff, 16'h0011);
    // Sleep: fast stops, low keeps running, wake reloads fast
    reg_wr(REG_OSC_CTRL, 16'h0d03);
    reg_wr(REG_PROTECT, UNLOCK_KEY);
    reg_wr(REG_SYSTEM_CORE_CLOCK, 16'h9011);
    pulse(2);
    chk_mode("sleep", MODE_SLEEP, 1'b0);
    chk("sleep runs", 16'h0002, {12'h0, osc_run});
    pulse(3);
    chk_mode("wake irq", MODE_RUN, 1'b1);
    rd_chk("reload", REG_SYSTEM_CORE_CLOCK, 16'hffff, 16'h9010);
    reg_wr(REG_SYSTEM_CORE_CLOCK, 16'h2001);
    pulse(2);
    pulse(4);
    chk_mode("wake nmi", MODE_RUN, 1'b1);
    rd_chk("no reload", REG_SYSTEM_CORE_CLOCK, 16'hffff, 16'h2001);
    // Halt, debug entry and exit, reset request
    pulse(1);
    chk_mode("halt", MODE_HALT, 1'b0);
    chk("halt runs", 16'h0003, {12'h0, osc_run});
    pulse(5);
    chk_mode("debug", MODE_DEBUG, 1'b1);
    pulse(6);
    chk_mode("debug ret", MODE_RUN, 1'b1);
    pulse(2);
    pulse(0);
    chk_mode("rst req", MODE_RUN, 1'b1);
    // Monitor output off, then divided by 1 and by 8
    mon_t = 0;
    repeat (60) @(posedge ref_clk);
    chk("mon off", 16'h0000, 16'(mon_t));
    reg_wr(REG_MONITOR, 16'h0001);
    mon_t = 0;
    clk_t = 0;
    repeat (200) @(posedge ref_clk);
    chk("mon div1", 16'h0001, {15'h0, mon_t inside {[40:50]}});
    // Low source at divide 1: one core enable per 410 ns low period
    chk("sys clk div1", 16'h0001, {15'h0, clk_t inside {[18:21]}});
    reg_wr(REG_MONITOR, 16'h0031);
    mon_t = 0;
    repeat (200) @(posedge ref_clk);
    chk("mon div8", 16'h0001, {15'h0, mon_t inside {[4:7]}});
    // Stop detection armed, crystal fails, hardware restarts it
    reg_wr(REG_INT_FLAG, 16'h0020);
    reg_wr(REG_INT_EN, 16'h0020);
    reg_wr(REG_PROTECT, UNLOCK_KEY);
    reg_wr(REG_LOW_CTRL, 16'h6000);
    reg_wr(REG_PROTECT, 16'h0000);
    low_fail <= 1'b1;
    wait_reg(REG_INT_FLAG, 16'h0020, 16'h0020);
    chk("stop irq", 16'h0001, {15'h0, irq});
    rd_chk("restart", REG_STATUS, 16'h0020, 16'h0000);
    low_fail <= 1'b0;
    wait_reg(REG_STATUS, 16'h0020, 16'h0020);
    reg_wr(REG_INT_FLAG, 16'h0020);
    rd_chk("stop clr", REG_INT_FLAG, 16'h0020, 16'h0000);
    reg_wr(REG_PROTECT, UNLOCK_KEY);
    reg_wr(REG_LOW_CTRL, 16'h4000);
    rd_chk("det off", REG_INT_FLAG, 16'h0020, 16'h0020);
    conclude();
  end
endmodule // testbench
